/* File: common/dpr_pkg.sv */
// constants and types for the dual-port ram port controller
package dpr_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int SEM_W = 3;
    localparam int CLK_NS = 50;
    // device timing, nanoseconds as printed for the slowest grade
    localparam int ADDR_SETUP_NS = 45;
    localparam int WRITE_PULSE_NS = 40;
    localparam int DATA_SETUP_NS = 25;
    localparam int HZWE_NS = 25;
    localparam int ACCESS_NS = 55;
    localparam int SEM_OP_NS = 20;
    localparam int PRIORITY_SETUP_TIME_NS = 5;
    localparam int FLAG_CONTENTION_WINDOW_NS = 5;
    // least times round up, at least one cycle
    function automatic int min_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int SETUP_CYC = min_cyc(ADDR_SETUP_NS);
    localparam int WP_OE_HI_CYC = min_cyc(WRITE_PULSE_NS);
    localparam int WP_OE_LO_CYC = min_cyc(
        (HZWE_NS + DATA_SETUP_NS > WRITE_PULSE_NS) ?
        HZWE_NS + DATA_SETUP_NS : WRITE_PULSE_NS);
    localparam int READ_CYC = min_cyc(ACCESS_NS);
    localparam int RECOVER_CYC = min_cyc(SEM_OP_NS);
    localparam int SYNC_STAGES = 2;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    typedef enum logic [2:0] {
        DPR_IDLE = 3'b000,
        DPR_SETUP = 3'b001,
        DPR_STROBE = 3'b010,
        DPR_HOLD = 3'b011,
        DPR_RECOVER = 3'b100
    } dpr_state_e;
endpackage

/* File: rtl/dpr_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module dpr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= INIT;
            dout <= INIT;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

/* File: rtl/dpr_port_ctrl.sv */
// host-side controller driving one port of the dual-port ram
// Summary of operation
// - reads keep the write strobe high for the whole cycle
// - array access: select low, semaphore high; semaphore: the reverse
// - first rising select or strobe ends write; data held across it
// - write strobe stays high whenever the address changes
// - strobe-ended write with output enable low is sized for HZWE_NS plus DATA_SETUP_NS, the same cycle count as oe high at CLK_NS 50
// - semaphore request writes low on data bit zero
// - each semaphore read gets its own strobed access
`timescale 1ns/100ps
module dpr_port_ctrl (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_sem,
    input wire logic req_oe_low,
    input wire logic [dpr_pkg::ADDR_W-1:0] req_addr,
    input wire logic [dpr_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [dpr_pkg::DATA_W-1:0] rsp_rdata,
    output logic rsp_busy_seen,
    output logic [dpr_pkg::ADDR_W-1:0] ram_addr,
    output logic ram_sel_n,
    output logic ram_sem_n,
    output logic ram_we_n,
    output logic ram_oe_n,
    input wire logic [dpr_pkg::DATA_W-1:0] ram_data_i,
    output logic [dpr_pkg::DATA_W-1:0] ram_data_o,
    output logic ram_data_oe,
    input wire logic ram_busy_n
);
    import dpr_pkg::*;

    // one register image; every output is a field of it
    typedef struct packed {
        dpr_state_e st;
        logic [3:0] cnt;
        logic wr;
        logic sem;
        logic oe_low;
        logic busy_hit;
        logic req_ready;
        logic rsp_valid;
        logic [DATA_W-1:0] rdata;
        logic rsp_busy;
        logic [ADDR_W-1:0] addr;
        logic sel_n;
        logic sem_n;
        logic we_n;
        logic oe_n;
        logic [DATA_W-1:0] dout;
        logic doe;
    } dpr_ctrl_s;

    dpr_ctrl_s s_q, s_d;
    logic [DATA_W-1:0] data_s;
    logic busy_n_s;

    // the word is taken only after it has stood two cycles past the flops,
    // so a change caught mid-flight never reaches the result
    dpr_sync #(.W(DATA_W), .INIT('0)) u_sync_data (
        .mclk(mclk),
        .nrst(nrst),
        .din(ram_data_i),
        .dout(data_s)
    );
    // idles high so leaving reset is not taken for a busy hit
    dpr_sync #(.W(1), .INIT(1'b1)) u_sync_busy (
        .mclk(mclk),
        .nrst(nrst),
        .din(ram_busy_n),
        .dout(busy_n_s)
    );

    function automatic logic [3:0] cyc4(input int c);
        return 4'(c);
    endfunction

    // counters run down to one; the count given is the number of cycles
    function automatic logic cnt_more(input logic [3:0] c);
        return c > 4'h1;
    endfunction

    function automatic logic [3:0] cnt_dec(input logic [3:0] c);
        return c - 4'h1;
    endfunction

    // the semaphore space has no busy arbitration
    function automatic logic held_off(input logic b_n, input logic sem);
        return !b_n && !sem;
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        case (s_q.st)
            DPR_IDLE: begin
                s_d.req_ready = 1'b1;
                if (req_valid && s_q.req_ready) begin
                    s_d.req_ready = 1'b0;
                    s_d.wr = req_write;
                    s_d.sem = req_sem;
                    s_d.oe_low = req_oe_low;
                    s_d.busy_hit = 1'b0;
                    // address moves only with strobe high
                    s_d.addr = req_addr;
                    s_d.we_n = 1'b1;
                    // semaphore value lives on bit zero only
                    s_d.dout = req_sem ?
                        {{(DATA_W-1){1'b1}}, req_wdata[0]} : req_wdata;
                    s_d.cnt = cyc4(SETUP_CYC);
                    s_d.st = DPR_SETUP;
                end
            end
            DPR_SETUP: begin
                // select and strobe fall together; the strobe rises first
                s_d.sel_n = s_q.sem;
                s_d.sem_n = !s_q.sem;
                s_d.oe_n = s_q.wr ? !s_q.oe_low : 1'b0;
                if (cnt_more(s_q.cnt)) begin
                    s_d.cnt = cnt_dec(s_q.cnt);
                end else begin
                    s_d.st = DPR_STROBE;
                    if (s_q.wr) begin
                        s_d.we_n = 1'b0;
                        s_d.doe = 1'b1;
                        // device may still drive when oe is low; the pulse
                        // also outlasts the busy synchroniser, else a slave
                        // inhibit would end unseen and the write be lost
                        s_d.cnt = cyc4(SYNC_STAGES + (s_q.oe_low ?
                            WP_OE_LO_CYC : WP_OE_HI_CYC));
                    end else begin
                        s_d.cnt = cyc4(READ_CYC + SYNC_STAGES);
                    end
                end
            end
            DPR_STROBE: begin
                // busy low means this port lost arbitration or is inhibited
                if (held_off(busy_n_s, s_q.sem)) begin
                    s_d.busy_hit = 1'b1;
                end
                if (cnt_more(s_q.cnt)) begin
                    s_d.cnt = cnt_dec(s_q.cnt);
                end else if (held_off(busy_n_s, s_q.sem)) begin
                    // stretch while busy; slave write is inhibited meanwhile
                    s_d.cnt = s_q.cnt;
                end else begin
                    if (s_q.wr) begin
                        // strobe rises first, data held one more cycle
                        s_d.we_n = 1'b1;
                        // oe leaves with the strobe so the device never
                        // turns its drivers on against the host's data
                        s_d.oe_n = 1'b1;
                    end else begin
                        s_d.rdata = data_s;
                    end
                    s_d.st = DPR_HOLD;
                end
            end
            DPR_HOLD: begin
                // every access ends with deselect, so sem reads re-strobe
                s_d.sel_n = 1'b1;
                s_d.sem_n = 1'b1;
                s_d.oe_n = 1'b1;
                s_d.doe = 1'b0;
                s_d.rsp_valid = 1'b1;
                s_d.rsp_busy = s_q.busy_hit;
                // sem bit zero low after a request means the grant came back
                if (!s_q.wr && s_q.sem) begin
                    s_d.rdata = {{(DATA_W-1){1'b0}}, s_q.rdata[0]};
                end
                s_d.cnt = cyc4(RECOVER_CYC);
                s_d.st = DPR_RECOVER;
            end
            DPR_RECOVER: begin
                // short gap so a semaphore update settles before next strobe
                if (cnt_more(s_q.cnt)) begin
                    s_d.cnt = cnt_dec(s_q.cnt);
                end else begin
                    s_d.req_ready = 1'b1;
                    s_d.st = DPR_IDLE;
                end
            end
            default: begin
                s_d.st = DPR_IDLE;
            end
        endcase
        // device floats its pins itself; host never drives during read
        if (!s_q.wr) begin
            s_d.doe = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{st: DPR_IDLE, cnt: CNT_ZERO, wr: 1'b0, sem: 1'b0,
                     oe_low: 1'b0, busy_hit: 1'b0, req_ready: 1'b0,
                     rsp_valid: 1'b0, rdata: '0, rsp_busy: 1'b0,
                     addr: '0, sel_n: 1'b1, sem_n: 1'b1, we_n: 1'b1,
                     oe_n: 1'b1, dout: '0, doe: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ready = s_q.req_ready;
    assign rsp_valid = s_q.rsp_valid;
    assign rsp_rdata = s_q.rdata;
    assign rsp_busy_seen = s_q.rsp_busy;
    assign ram_addr = s_q.addr;
    assign ram_sel_n = s_q.sel_n;
    assign ram_sem_n = s_q.sem_n;
    assign ram_we_n = s_q.we_n;
    assign ram_oe_n = s_q.oe_n;
    assign ram_data_o = s_q.dout;
    assign ram_data_oe = s_q.doe;
endmodule

/* File: verif/dpr_port_ctrl_assertions.sv */
// pin-level and request/response assertions for the port controller
`timescale 1ns/100ps
module dpr_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic rsp_busy_seen,
    input wire logic [dpr_pkg::ADDR_W-1:0] ram_addr,
    input wire logic ram_sel_n,
    input wire logic ram_sem_n,
    input wire logic ram_we_n,
    input wire logic ram_oe_n,
    input wire logic [dpr_pkg::DATA_W-1:0] ram_data_o,
    input wire logic ram_data_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    property p_rd; !ram_data_oe |-> ram_we_n; endproperty
    a_rd: assert property (p_rd) else $error("strobe low on read");
    property p_sp; ram_sel_n || ram_sem_n; endproperty
    a_sp: assert property (p_sp) else $error("both selects low");
    property p_end; $rose(ram_we_n) |-> ram_data_oe && $stable(ram_data_o);
    endproperty
    a_end: assert property (p_end) else $error("data moved at end");
    property p_adr; !$stable(ram_addr) |-> ram_we_n && $past(ram_we_n);
    endproperty
    a_adr: assert property (p_adr) else $error("addr moved in write");
    property p_wp; !ram_we_n |-> ram_data_oe && !(ram_sel_n && ram_sem_n);
    endproperty
    a_wp: assert property (p_wp) else $error("bad write pulse");
    property p_sm; !ram_sem_n && !ram_we_n |-> ram_data_o[7:1] == 7'h7F;
    endproperty
    a_sm: assert property (p_sm) else $error("sem data high bits");
    property p_sr; $fell(ram_sem_n) |-> ##[1:8] ram_sem_n; endproperty
    a_sr: assert property (p_sr) else $error("sem select stuck");
    property p_dn; req_valid && req_ready |-> ##[2:60] rsp_valid; endproperty
    a_dn: assert property (p_dn) else $error("access never ends");
    c_wr: cover property (!ram_we_n && !ram_oe_n);
    c_sem: cover property (!ram_sem_n && !ram_we_n);
    c_bsy: cover property (rsp_valid && rsp_busy_seen);
endmodule
bind dpr_port_ctrl dpr_chk dpr_chk_i (.mclk, .nrst, .req_valid, .req_ready,
    .rsp_valid, .rsp_busy_seen, .ram_addr, .ram_sel_n, .ram_sem_n,
    .ram_we_n, .ram_oe_n, .ram_data_o, .ram_data_oe);

/* File: verif/dpr_dev_model.sv */
// behavioural model of the ram device behind one port
`timescale 1ns/100ps
module dpr_dev_model import dpr_pkg::*; (
    input wire logic [ADDR_W-1:0] addr,
    input wire logic sel_n,
    input wire logic sem_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [DATA_W-1:0] din,
    output logic [DATA_W-1:0] dout,
    output logic busy_n,
    input wire logic [7:0] r_sem,
    input wire logic r_on,
    input wire logic r_wr,
    input wire logic [ADDR_W-1:0] r_addr
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] last = 8'h00;
    logic [7:0] own = 8'h00;
    logic arr;
    wire logic wr = !we_n && !(sel_n && sem_n);
    wire logic rd = we_n && !oe_n && !(sel_n && sem_n);
    // space latched while writing, either strobe may end it
    always @* if (wr) arr = !sel_n;
    always @(negedge wr) begin
        if (arr) mem[addr] = din;
        else if (din[0]) own[addr[2:0]] = 1'b0;
        else if (!r_sem[addr[2:0]]) own[addr[2:0]] = 1'b1;
    end
    always @* if (rd) last = sem_n ? mem[addr] : {7'h00, !own[addr[2:0]]};
    // released pins show the inverse so stale data cannot pass
    assign dout = rd ? last : ~last;
    // a writer facing a reader on the far port keeps its busy high
    assign busy_n = !(r_on && !sel_n && addr == r_addr
        && (r_wr || we_n));
endmodule

/* File: verif/dpr_port_ctrl_bench.sv */
// self-checking bench for the port controller
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module dpr_port_ctrl_bench;
    import dpr_pkg::*;
    logic mclk = 0, nrst = 0, req_valid = 0, req_write = 0, req_sem = 0;
    logic req_oe_low = 0, req_ready, rsp_valid, rsp_busy_seen, ram_sel_n;
    logic ram_sem_n, ram_we_n, ram_oe_n, ram_data_oe, ram_busy_n, r_on = 0;
    logic [ADDR_W-1:0] req_addr = '0, ram_addr, r_addr = '0;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, ram_data_o, dv, pin;
    logic [7:0] r_sem = 8'h00;
    logic r_wr = 0;
    logic [31:0] seed = 32'h3F22;
    int n_mismatch = 0, comparisons = 0;
    assign pin = ram_data_oe ? ram_data_o : dv;
    dpr_port_ctrl dpr_port_ctrl_i (.mclk, .nrst, .req_valid, .req_write,
        .req_sem, .req_oe_low, .req_addr, .req_wdata, .req_ready, .rsp_valid,
        .rsp_rdata, .rsp_busy_seen, .ram_addr, .ram_sel_n, .ram_sem_n,
        .ram_we_n, .ram_oe_n, .ram_data_i(pin), .ram_data_o, .ram_data_oe,
        .ram_busy_n);
    dpr_dev_model dpr_dev_model_i (.addr(ram_addr), .sel_n(ram_sel_n),
        .sem_n(ram_sem_n), .we_n(ram_we_n), .oe_n(ram_oe_n), .din(pin),
        .dout(dv), .busy_n(ram_busy_n), .r_sem, .r_on, .r_wr, .r_addr);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] sem_exp(input logic won);
        return {7'h00, !won};
    endfunction
    task automatic step();
        @(posedge mclk);
        #1;
    endtask
    task automatic acc(input logic w, s, o, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        int n = 0;
        {req_write, req_sem, req_oe_low, req_addr, req_wdata} = {w, s, o, a, d};
        req_valid = 1;
        while (req_ready !== 1'b1 && n < 50) begin
            step();
            n++;
        end
        step();
        req_valid = 0;
        while (rsp_valid !== 1'b1 && n < 200) begin
            step();
            n++;
        end
        if (n >= 200) n_mismatch++;
    endtask
    task automatic test_done();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        forever #(CLK_NS / 2) mclk = ~mclk;
    end
    initial begin
        #(CLK_NS * 5000);
        n_mismatch++;
        test_done();
    end
    initial begin
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        repeat (4) @(posedge mclk);
        #1 nrst = 1;
        for (int i = 0; i < 12; i++) begin
            a = (i == 0) ? '1 : (i == 1) ? '0 : ADDR_W'(rnd());
            d = DATA_W'(rnd());
            acc(1, 0, i[0], a, d);
            acc(0, 0, 0, a, 8'h00);
            `CHK(rsp_rdata, d)
        end
        $display("test array done");
        acc(1, 1, 0, 13'h0003, 8'hFE);
        acc(0, 1, 0, 13'h0003, 8'h00);
        `CHK(rsp_rdata, sem_exp(1))
        r_sem = 8'h20;
        acc(1, 1, 0, 13'h0005, 8'hFE);
        acc(0, 1, 0, 13'h0005, 8'h00);
        `CHK(rsp_rdata, sem_exp(0))
        acc(1, 1, 0, 13'h0003, 8'hFF);
        acc(0, 1, 0, 13'h0003, 8'h00);
        `CHK(rsp_rdata, sem_exp(0))
        $display("test semaphore done");
        r_addr = a;
        d = DATA_W'(rnd());
        r_on = 1;
        acc(1, 0, 0, a, ~d);
        `CHK(rsp_busy_seen, 1'b0)
        r_wr = 1;
        // busy write first, then a busy read that must return its data
        for (int w = 1; w >= 0; w--) begin
            r_on = 1;
            fork
                acc(w[0], 0, 0, a, d);
                begin
                    repeat (10) step();
                    r_on = 0;
                end
            join
            `CHK(rsp_busy_seen, 1'b1)
        end
        `CHK(rsp_rdata, d)
        r_on = 1;
        acc(0, 0, 0, ~a, 8'h00);
        `CHK(rsp_busy_seen, 1'b0)
        r_on = 0;
        $display("test busy done");
        test_done();
    end
endmodule
